// ### lps_top.sv
// Purpose: Register file, serial bus slave and proximity timing of the sensor.
// Assumes: Open-drain bus pins; analog values arrive on CLK as plain inputs.
// Notes: The register pointer survives a stop and advances after each data byte written or read.
`timescale 1ns/1ps

// Contract
// - Modulator register upper bits set emitter delay.
// - Lower bits set dead time blanking.
// - No measurement means standby, emitter sink off.
// - Pointer write alone, then read returns it.
// - Stop-start or repeated start both work.
// - Pointer increments after each byte read.
// - Answer write byte 26h, read 27h.
// - Standard mode uses fixed 100 ms frame.
// - Standard result appears only after frame.
// - Continuous mode runs conversions back to back.
// - Up to 128 conversions, result averaged.
// - Averaging is two to field; default 32.
// - Result high byte 85h, low 86h.
module lps_top
   import lps_pkg::*;
#(
   parameter int unsigned FRAME_CYC = LPS_FRAME_CYC,
   parameter int unsigned CONV_CYC = LPS_CONV_CYC,
   parameter int unsigned PRX_CYC = LPS_PRX_CYC
)
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic SRST,
   // Serial bus pins.
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   // Analog front end values.
   input wire logic [15:0] ALS_SAMPLE,
   input wire logic [15:0] PRX_SAMPLE,
   // Front end controls.
   output logic LED_SINK_EN,
   output logic [5:0] LED_CURRENT,
   output logic [1:0] PRX_FREQ,
   output logic [2:0] MOD_DELAY,
   output logic [2:0] MOD_DEAD,
   output logic ALS_CONV,
   output logic STANDBY
);
   // Bus slave states.
   typedef enum logic [2:0] {
      I_IDLE = 3'b000,
      I_ADDR = 3'b001,
      I_AACK = 3'b010,
      I_PTR = 3'b011,
      I_WDAT = 3'b100,
      I_WACK = 3'b101,
      I_RDAT = 3'b110,
      I_RACK = 3'b111
   } lps_i2c_st_t;

   // Whole state of the top module.
   typedef struct packed {
      lps_i2c_st_t st;            // Bus slave state.
      logic [3:0] bits;           // Bits moved in the current byte.
      logic [7:0] sh;             // Shift register.
      logic [7:0] ptr;            // Register pointer.
      logic rd;                   // Current transfer is a read.
      logic nack;                 // Host refused the last read byte.
      logic scl_d;                // Previous synchronised clock.
      logic sda_d;                // Previous synchronised data.
      logic sda_o;                // Data output level when enabled.
      logic sda_oe;               // Data pulled low.
      logic [5:0] led_cur;        // Emitter current setting.
      logic als_cont;             // Continuous conversion bit.
      logic [2:0] als_avg;        // Averaging exponent.
      logic [1:0] frq;            // Proximity frequency.
      logic [7:0] mod_tim;        // Modulator timing byte.
      logic als_rdy;              // Ambient result ready.
      logic prx_rdy;              // Proximity result ready.
      logic als_start;            // Start pulse to the ambient engine.
      logic prx_busy;             // Proximity measurement running.
      logic [LPS_CNT_W-1:0] pcnt; // Proximity cycle counter.
      logic [15:0] prx_res;       // Proximity result.
      logic led_en;               // Emitter sink enable.
      logic stby;                 // Standby indication.
   } lps_top_s_t;

   lps_top_s_t s_r;   // Registered state.
   lps_top_s_t s_nxt; // Next state.
   logic [1:0] pins;  // Synchronised clock and data.
   logic scl;         // Synchronised clock.
   logic sda;         // Synchronised data.
   logic start_c;     // Start or repeated start seen.
   logic stop_c;      // Stop seen.
   logic scl_rise;    // Clock rising edge.
   logic scl_fall;    // Clock falling edge.
   logic wr_en;       // Data byte write strobe.
   logic [7:0] rd_byte; // Byte at the pointer.

   lps_als_if als_bus ();

   // Both bus pins pass two flip-flops before use.
   lps_sync u_sync (
      .clk(CLK),
      .srst(SRST),
      .d({SCL_I, SDA_I}),
      .q(pins)
   );

   // Ambient light engine.
   lps_als #(
      .FRAME_CYC(FRAME_CYC),
      .CONV_CYC(CONV_CYC)
   ) u_als (
      .clk(CLK),
      .srst(SRST),
      .als(als_bus.eng)
   );

   // Read decode of the register space.
   function automatic logic [7:0] lps_rd(input lps_top_s_t s, input logic [15:0] als_res,
      input logic als_busy, input logic [7:0] adr);
      logic [7:0] v;
      v = 8'h00;
      unique case (adr)
         LPS_REG_CMD: begin
            v[LPS_CMD_ALS_RDY] = s.als_rdy;
            v[LPS_CMD_PRX_RDY] = s.prx_rdy;
            v[LPS_CMD_ALS_DEM] = als_busy;
            v[LPS_CMD_PRX_DEM] = s.prx_busy;
         end
         LPS_REG_LED_CUR: v = {2'h0, s.led_cur};
         LPS_REG_ALS_PAR: begin
            v[LPS_ALS_CONT] = s.als_cont;
            v[LPS_AVG_MSB:0] = s.als_avg;
         end
         LPS_REG_ALS_HI: v = als_res[15:8];
         LPS_REG_ALS_LO: v = als_res[7:0];
         LPS_REG_PRX_HI: v = s.prx_res[15:8];
         LPS_REG_PRX_LO: v = s.prx_res[7:0];
         LPS_REG_PRX_FRQ: v = {6'h00, s.frq};
         LPS_REG_MOD_TIM: v = s.mod_tim;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   assign scl = pins[1];
   assign sda = pins[0];
   assign start_c = scl && s_r.scl_d && s_r.sda_d && !sda;
   assign stop_c = scl && s_r.scl_d && !s_r.sda_d && sda;
   assign scl_rise = scl && !s_r.scl_d;
   assign scl_fall = !scl && s_r.scl_d;
   assign rd_byte = lps_rd(s_r, als_bus.result, als_bus.busy, s_r.ptr);

   // Bus slave, register writes and proximity sequencing.
   always_comb begin
      s_nxt = s_r;
      wr_en = 1'b0;
      s_nxt.scl_d = scl;
      s_nxt.sda_d = sda;
      s_nxt.als_start = 1'b0;
      if (start_c) begin
         // A repeated start is as good as stop then start.
         s_nxt.st = I_ADDR;
         s_nxt.bits = 4'h0;
         s_nxt.sda_oe = 1'b0;
      end else if (stop_c) begin
         // The pointer is kept across the stop for the later read.
         s_nxt.st = I_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else begin
         unique case (s_r.st)
            I_IDLE: begin
               s_nxt.sda_oe = 1'b0;
            end
            I_ADDR, I_PTR, I_WDAT: begin
               if (scl_rise) begin
                  s_nxt.sh = {s_r.sh[6:0], sda};
                  s_nxt.bits = s_r.bits + 1'b1;
               end else if (scl_fall && s_r.bits == 4'h8) begin
                  s_nxt.bits = 4'h0;
                  if (s_r.st == I_ADDR) begin
                     // Only bytes 26h and 27h are acknowledged.
                     if (s_r.sh[7:1] == LPS_DEV_ADDR) begin
                        s_nxt.rd = s_r.sh[0];
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.st = I_AACK;
                     end else begin
                        s_nxt.st = I_IDLE;
                     end
                  end else if (s_r.st == I_PTR) begin
                     // A write with only this byte just sets the pointer.
                     s_nxt.ptr = s_r.sh;
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.st = I_WACK;
                  end else begin
                     wr_en = 1'b1;
                     s_nxt.ptr = s_r.ptr + 1'b1;
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.st = I_WACK;
                  end
               end
            end
            I_AACK: begin
               if (scl_fall) begin
                  if (s_r.rd) begin
                     // Read returns the register the pointer names.
                     s_nxt.sh = {rd_byte[6:0], 1'b0};
                     s_nxt.sda_oe = !rd_byte[7];
                     s_nxt.bits = 4'h1;
                     s_nxt.st = I_RDAT;
                  end else begin
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.st = I_PTR;
                  end
               end
            end
            I_WACK: begin
               if (scl_fall) begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.st = I_WDAT;
               end
            end
            I_RDAT: begin
               if (scl_fall) begin
                  if (s_r.bits == 4'h8) begin
                     // Each byte read moves the pointer on.
                     s_nxt.ptr = s_r.ptr + 1'b1;
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.st = I_RACK;
                  end else begin
                     s_nxt.sda_oe = !s_r.sh[7];
                     s_nxt.sh = {s_r.sh[6:0], 1'b0};
                     s_nxt.bits = s_r.bits + 1'b1;
                  end
               end
            end
            I_RACK: begin
               if (scl_rise) begin
                  s_nxt.nack = sda;
               end else if (scl_fall) begin
                  if (s_r.nack) begin
                     s_nxt.st = I_IDLE;
                  end else begin
                     // The next register follows without a new pointer.
                     s_nxt.sh = {rd_byte[6:0], 1'b0};
                     s_nxt.sda_oe = !rd_byte[7];
                     s_nxt.bits = 4'h1;
                     s_nxt.st = I_RDAT;
                  end
               end
            end
         endcase
      end

      // Register writes; the reserved register ignores them.
      if (wr_en) begin
         unique case (s_r.ptr)
            LPS_REG_CMD: begin
               if (s_r.sh[LPS_CMD_ALS_DEM] && !als_bus.busy) begin
                  s_nxt.als_start = 1'b1;
                  s_nxt.als_rdy = 1'b0;
               end
               if (s_r.sh[LPS_CMD_PRX_DEM] && !s_r.prx_busy) begin
                  s_nxt.prx_busy = 1'b1;
                  s_nxt.prx_rdy = 1'b0;
                  s_nxt.pcnt = '0;
               end
            end
            LPS_REG_LED_CUR: s_nxt.led_cur = s_r.sh[5:0];
            LPS_REG_ALS_PAR: begin
               s_nxt.als_cont = s_r.sh[LPS_ALS_CONT];
               s_nxt.als_avg = s_r.sh[LPS_AVG_MSB:0];
            end
            LPS_REG_PRX_FRQ: s_nxt.frq = s_r.sh[1:0];
            // Delay and dead time are kept; bits 4 and 3 read zero.
            LPS_REG_MOD_TIM: s_nxt.mod_tim = {s_r.sh[7:LPS_DLY_LSB], 2'h0,
               s_r.sh[LPS_DEAD_MSB:0]};
            default: begin
            end
         endcase
      end

      // Proximity measurement: emitter on for a fixed time, then capture.
      if (s_r.prx_busy) begin
         s_nxt.pcnt = s_r.pcnt + 1'b1;
         if (s_r.pcnt == LPS_CNT_W'(PRX_CYC - 1)) begin
            s_nxt.prx_busy = 1'b0;
            s_nxt.prx_res = PRX_SAMPLE;
            s_nxt.prx_rdy = 1'b1;
         end
      end
      // A finished ambient measurement sets its flag after any clear.
      if (als_bus.done) begin
         s_nxt.als_rdy = 1'b1;
      end

      // Without a measurement the sink is off whatever the current setting.
      s_nxt.led_en = s_nxt.prx_busy;
      s_nxt.stby = !(s_nxt.prx_busy || als_bus.busy || s_r.als_start || s_nxt.als_start);
   end

   // Register the state.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_r <= '{st: I_IDLE, scl_d: 1'b1, sda_d: 1'b1, led_cur: LPS_LED_RST,
            als_avg: LPS_AVG_RST, frq: LPS_FRQ_RST, mod_tim: LPS_MOD_RST,
            stby: 1'b1, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Requests to the ambient engine.
   assign als_bus.start = s_r.als_start;
   assign als_bus.cont = s_r.als_cont;
   assign als_bus.avg = s_r.als_avg;
   assign als_bus.sample = ALS_SAMPLE;

   // Outputs, each from a flip-flop.
   assign SDA_O = s_r.sda_o;
   assign SDA_OE = s_r.sda_oe;
   assign LED_SINK_EN = s_r.led_en;
   assign LED_CURRENT = s_r.led_cur;
   assign PRX_FREQ = s_r.frq;
   assign MOD_DELAY = s_r.mod_tim[7:LPS_DLY_LSB];
   assign MOD_DEAD = s_r.mod_tim[LPS_DEAD_MSB:0];
   assign ALS_CONV = als_bus.conv;
   assign STANDBY = s_r.stby;
endmodule

// ### lps_pkg.sv
// Purpose: Shared constants for the light and proximity sensor access and timing logic.
// Assumes: A 100 MHz system clock and a two-wire serial bus at device address 26h/27h.
// Notes: Timing counts are derived here from times in their own units.
package lps_pkg;
   // Seven-bit bus address; the write byte is 26h and the read byte is 27h.
   localparam logic [6:0] LPS_DEV_ADDR = 7'h13;
   // Register offsets.
   localparam logic [7:0] LPS_REG_CMD = 8'h80;
   localparam logic [7:0] LPS_REG_LED_CUR = 8'h83;
   localparam logic [7:0] LPS_REG_ALS_PAR = 8'h84;
   localparam logic [7:0] LPS_REG_ALS_HI = 8'h85;
   localparam logic [7:0] LPS_REG_ALS_LO = 8'h86;
   localparam logic [7:0] LPS_REG_PRX_HI = 8'h87;
   localparam logic [7:0] LPS_REG_PRX_LO = 8'h88;
   localparam logic [7:0] LPS_REG_PRX_FRQ = 8'h89;
   localparam logic [7:0] LPS_REG_MOD_TIM = 8'h8a;
   localparam logic [7:0] LPS_REG_AMB_IR = 8'h8b;
   // Command register bit positions.
   localparam int LPS_CMD_ALS_RDY = 6;
   localparam int LPS_CMD_PRX_RDY = 5;
   localparam int LPS_CMD_ALS_DEM = 4;
   localparam int LPS_CMD_PRX_DEM = 3;
   // Ambient parameter fields: continuous bit and averaging field.
   localparam int LPS_ALS_CONT = 7;
   localparam int LPS_AVG_MSB = 2;
   // Modulator timing fields: delay in the upper bits, dead time in the lower bits.
   localparam int LPS_DLY_LSB = 5;
   localparam int LPS_DEAD_MSB = 2;
   // Reset values.
   localparam logic [2:0] LPS_AVG_RST = 3'h5;
   localparam logic [1:0] LPS_FRQ_RST = 2'h2;
   localparam logic [5:0] LPS_LED_RST = 6'h02;
   localparam logic [7:0] LPS_MOD_RST = 8'h00;
   // Clock rate and timing.
   localparam int LPS_CLK_KHZ = 100000;
   localparam int LPS_FRAME_MS = 100;
   localparam int LPS_CONV_US = 300;
   localparam int LPS_PRX_US = 200;
   localparam int LPS_FRAME_CYC = LPS_FRAME_MS * LPS_CLK_KHZ;
   localparam int LPS_CONV_CYC = (LPS_CONV_US * LPS_CLK_KHZ) / 1000;
   localparam int LPS_PRX_CYC = (LPS_PRX_US * LPS_CLK_KHZ) / 1000;
   // Width of the timing counters.
   localparam int LPS_CNT_W = 24;
endpackage

// ### lps_als_if.sv
// Purpose: Carries the ambient light request and result between control and engine.
// Assumes: Both ends run on the same clock.
// Notes: The control side issues one-cycle start pulses.
`timescale 1ns/1ps
interface lps_als_if;
   logic start;          // One-cycle request for a measurement.
   logic cont;           // Continuous conversion mode.
   logic [2:0] avg;      // Averaging exponent.
   logic [15:0] sample;  // Converter value at the end of each conversion.
   logic busy;           // A measurement is in progress.
   logic done;           // One-cycle pulse when the result is published.
   logic conv;           // A single conversion is running.
   logic [15:0] result;  // Averaged result.
   modport ctl (output start, output cont, output avg, output sample,
      input busy, input done, input conv, input result);
   modport eng (input start, input cont, input avg, input sample,
      output busy, output done, output conv, output result);
endinterface

// ### lps_sync.sv
// Purpose: Two-stage synchroniser for the serial bus pins.
// Assumes: Inputs are asynchronous to CLK.
// Notes: Only the second stage leaves this module.
`timescale 1ns/1ps
module lps_sync
   import lps_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Pins in and synchronised copies out.
   input wire logic [1:0] d,
   output logic [1:0] q
);
   // Both stages form the whole state of this module.
   typedef struct packed {
      logic [1:0] s1;  // First stage, read only by the second stage.
      logic [1:0] s2;  // Second stage.
   } lps_sync_t;

   lps_sync_t st_r;   // Registered state.
   lps_sync_t st_nxt; // Next state.

   // Shift the pins through both stages; idle bus lines are high.
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   // Register the state; reset to the idle level of the bus.
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '{s1: 2'h3, s2: 2'h3};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule

// ### lps_als.sv
// Purpose: Ambient light measurement sequencer with averaging and frame timing.
// Assumes: The sample input is valid at the end of each conversion.
// Notes: In standard mode the result waits for the end of the frame.
`timescale 1ns/1ps
module lps_als
   import lps_pkg::*;
#(
   parameter int unsigned FRAME_CYC = LPS_FRAME_CYC,
   parameter int unsigned CONV_CYC = LPS_CONV_CYC
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Request and result.
   lps_als_if.eng als
);
   // Sequencer states.
   typedef enum logic [1:0] {
      A_IDLE = 2'b00,
      A_CONV = 2'b01,
      A_WAIT = 2'b10
   } lps_als_st_t;

   // Whole state of the sequencer.
   typedef struct packed {
      lps_als_st_t st;           // Sequencer state.
      logic cont;                // Latched continuous mode.
      logic [2:0] avg;           // Latched averaging exponent.
      logic [7:0] left;          // Conversions still to run.
      logic [LPS_CNT_W-1:0] cyc; // Cycles within one conversion.
      logic [LPS_CNT_W-1:0] frm; // Cycles since the frame began.
      logic [22:0] sum;          // Sum of the conversions so far.
      logic busy;                // Measurement in progress.
      logic done;                // Result publish pulse.
      logic conv;                // Conversion running.
      logic [15:0] result;       // Published average.
   } lps_als_s_t;

   lps_als_s_t s_r;   // Registered state.
   lps_als_s_t s_nxt; // Next state.
   logic [22:0] sum_new; // Sum including the sample that just finished.

   // Advance the conversions and decide when the result is published.
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      sum_new = s_r.sum + {7'h00, als.sample};
      unique case (s_r.st)
         A_IDLE: begin
            if (als.start) begin
               // Two raised to the averaging field, 1 to 128 conversions.
               s_nxt.left = 8'(8'h01 << als.avg);
               s_nxt.cont = als.cont;
               s_nxt.avg = als.avg;
               s_nxt.cyc = '0;
               s_nxt.frm = '0;
               s_nxt.sum = '0;
               s_nxt.busy = 1'b1;
               s_nxt.conv = 1'b1;
               s_nxt.st = A_CONV;
            end
         end
         A_CONV: begin
            s_nxt.cyc = s_r.cyc + 1'b1;
            s_nxt.frm = s_r.frm + 1'b1;
            if (s_r.cyc == LPS_CNT_W'(CONV_CYC - 1)) begin
               // Conversions run back to back in both modes.
               s_nxt.cyc = '0;
               s_nxt.sum = sum_new;
               s_nxt.left = s_r.left - 1'b1;
               if (s_r.left == 8'h01) begin
                  s_nxt.conv = 1'b0;
                  if (s_r.cont) begin
                     // Continuous mode publishes at once, the average of all.
                     s_nxt.result = 16'(sum_new >> s_r.avg);
                     s_nxt.done = 1'b1;
                     s_nxt.busy = 1'b0;
                     s_nxt.st = A_IDLE;
                  end else begin
                     s_nxt.st = A_WAIT;
                  end
               end
            end
         end
         A_WAIT: begin
            // Standard mode holds the result until the fixed frame ends.
            s_nxt.frm = s_r.frm + 1'b1;
            if (s_r.frm >= LPS_CNT_W'(FRAME_CYC - 1)) begin
               s_nxt.result = 16'(s_r.sum >> s_r.avg);
               s_nxt.done = 1'b1;
               s_nxt.busy = 1'b0;
               s_nxt.st = A_IDLE;
            end
         end
         default: begin
            s_nxt.st = A_IDLE;
         end
      endcase
   end

   // Register the state.
   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '{st: A_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign als.busy = s_r.busy;
   assign als.done = s_r.done;
   assign als.conv = s_r.conv;
   assign als.result = s_r.result;
endmodule

// ### lps_sva.sv
// Purpose: Port checker for the sensor register and timing top.
// Assumes: Bound to lps_top and handed its conversion length.
// Notes: One clock domain, so clocking and disable are given once.
`timescale 1ns/1ps
module lps_sva
   import lps_pkg::*;
#(
   parameter int unsigned CONV_CYC = LPS_CONV_CYC
)
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic SRST,
   // Bus pins.
   input wire logic SCL_I,
   input wire logic SDA_O,
   input wire logic SDA_OE,
   // Front end controls.
   input wire logic LED_SINK_EN,
   input wire logic [2:0] MOD_DELAY,
   input wire logic [2:0] MOD_DEAD,
   input wire logic ALS_CONV,
   input wire logic STANDBY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   int unsigned run_r; // Length of the current conversion run.
   // Counts consecutive conversion cycles.
   always_ff @(posedge CLK) begin
      run_r <= (SRST || !ALS_CONV) ? 0 : run_r + 1;
   end
   // A conversion, once begun, lasts eight cycles at least.
   sequence s_conv_hold;
      ALS_CONV [*8];
   endsequence
   property p_sink_idle; STANDBY |-> !LED_SINK_EN; endproperty
   property p_conv_idle; STANDBY |-> !ALS_CONV; endproperty
   property p_conv_wake; $rose(ALS_CONV) |-> !STANDBY throughout s_conv_hold; endproperty
   property p_conv_max; run_r <= 128 * CONV_CYC; endproperty
   property p_dly_when; !$stable(MOD_DELAY) |-> !$past(SCL_I) && !$past(SCL_I, 3); endproperty
   property p_dead_when; !$stable(MOD_DEAD) |-> !$past(SCL_I) && !$past(SCL_I, 3); endproperty
   property p_oe_when; $changed(SDA_OE) |-> $past(SCL_I, 2) == 1'b0; endproperty
   property p_sda_low; SDA_O == 1'b0; endproperty
   a_sink_idle: assert property (p_sink_idle)
      else $error("sink on in standby");
   a_conv_idle: assert property (p_conv_idle)
      else $error("conversion in standby");
   a_conv_wake: assert property (p_conv_wake)
      else $error("short conversion");
   a_conv_max: assert property (p_conv_max)
      else $error("conversion run too long");
   a_dly_when: assert property (p_dly_when)
      else $error("delay changed off a write");
   a_dead_when: assert property (p_dead_when)
      else $error("dead time changed off a write");
   a_oe_when: assert property (p_oe_when)
      else $error("data changed while clock high");
   a_sda_low: assert property (p_sda_low)
      else $error("data pin driven high");
endmodule
bind lps_top lps_sva #(.CONV_CYC(CONV_CYC)) u_sva (.CLK(CLK), .SRST(SRST), .SCL_I(SCL_I),
   .SDA_O(SDA_O), .SDA_OE(SDA_OE), .LED_SINK_EN(LED_SINK_EN), .MOD_DELAY(MOD_DELAY),
   .MOD_DEAD(MOD_DEAD), .ALS_CONV(ALS_CONV), .STANDBY(STANDBY));

// ### lps_host.sv
// Purpose: Two-wire bus host model driving the sensor pins.
// Assumes: Clock phases of at least eight cycles.
// Notes: A one on sda releases the line.
`timescale 1ns/1ps
module lps_host (
   // Clock.
   input wire logic clk,
   // Driven lines and the resolved data wire.
   output logic scl,
   output logic sda,
   input wire logic sda_line
);
   // The bus starts idle.
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // One clock pulse: data a, then b while high; lo drops the clock.
   task automatic bitx(input logic a, input logic b, input logic lo, output logic r);
      sda <= a;
      repeat (8) @(posedge clk);
      scl <= 1'b1;
      repeat (8) @(posedge clk);
      r = sda_line;
      sda <= b;
      repeat (4) @(posedge clk);
      scl <= !lo;
      repeat (2) @(posedge clk);
   endtask
   // Sends a byte, top bit first, and returns the acknowledge.
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(b[i], b[i], 1'b1, r);
      bitx(1'b1, 1'b1, 1'b1, r);
      ack = !r;
   endtask
   // Reads a byte and refuses further bytes when last is set.
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, 1'b1, 1'b1, b[i]);
      bitx(last, last, 1'b1, r);
   endtask
endmodule

// ### light_prox_sensor_access_timing_test.sv
// Purpose: Self-checking bench for the sensor register and timing top.
// Assumes: Frame and conversion counts shortened below.
// Notes: Counters watch the front end pins during measurements.
`timescale 1ns/1ps
module light_prox_sensor_access_timing_test
   import lps_pkg::*;
;
   localparam int unsigned FRM = 2000;
   localparam int unsigned CNV = 20;
   logic clk, srst, scl, sda, sda_o, sda_oe, sink, conv, stby, ack, r;
   logic [2:0] dly, dead;
   logic [5:0] cur;
   logic [1:0] frq;
   logic [15:0] als_smp;
   logic [7:0] rb [2];
   int error_cnt, samples_checked, conv_cnt, sink_cnt, stby_cnt;
   wire logic sda_line = sda & ~(sda_oe & ~sda_o);
   lps_top #(.FRAME_CYC(FRM), .CONV_CYC(CNV), .PRX_CYC(30)) u_dut (.CLK(clk), .SRST(srst),
      .SCL_I(scl), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE(sda_oe), .ALS_SAMPLE(als_smp),
      .PRX_SAMPLE(16'h5a3c), .LED_SINK_EN(sink), .LED_CURRENT(cur), .PRX_FREQ(frq),
      .MOD_DELAY(dly), .MOD_DEAD(dead), .ALS_CONV(conv), .STANDBY(stby));
   lps_host u_host (.clk(clk), .scl(scl), .sda(sda), .sda_line(sda_line));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counts conversion, emitter and busy cycles.
   always @(posedge clk) begin
      conv_cnt <= conv_cnt + int'(conv === 1'b1);
      sink_cnt <= sink_cnt + int'(sink === 1'b1);
      stby_cnt <= stby_cnt + int'(stby === 1'b0);
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Writes one register: device byte, pointer, data.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host.bitx(1'b1, 1'b0, 1'b1, r);
      u_host.wbyte(8'h26, ack);
      chk(16'(ack), 16'h1);
      u_host.wbyte(a, ack);
      u_host.wbyte(d, ack);
      u_host.bitx(1'b0, 1'b1, 1'b0, r);
   endtask
   // Reads n bytes from a; rs picks a repeated start over stop and start.
   task automatic rd(input logic [7:0] a, input logic rs, input int n);
      u_host.bitx(1'b1, 1'b0, 1'b1, r);
      u_host.wbyte(8'h26, ack);
      u_host.wbyte(a, ack);
      if (!rs)
         u_host.bitx(1'b0, 1'b1, 1'b0, r);
      u_host.bitx(1'b1, 1'b0, 1'b1, r);
      u_host.wbyte(8'h27, ack);
      chk(16'(ack), 16'h1);
      for (int i = 0; i < n; i++)
         u_host.rbyte(i == n - 1, rb[i]);
      u_host.bitx(1'b0, 1'b1, 1'b0, r);
   endtask
   // Runs one measurement with mode byte par and command cmd.
   task automatic meas(input logic [7:0] par, input logic [7:0] cmd);
      wr(LPS_REG_ALS_PAR, par);
      @(negedge clk);
      conv_cnt = 0;
      sink_cnt = 0;
      stby_cnt = 0;
      wr(LPS_REG_CMD, cmd);
      for (int k = 0; k < 4000 && !(stby === 1'b1 && stby_cnt > 0); k++)
         @(posedge clk);
      @(negedge clk);
      chk(16'(sink_cnt), cmd[3] ? 16'h1e : 16'h0);
      chk(16'(conv_cnt), cmd[3] ? 16'h0 : 16'(CNV << par[2:0]));
      if (!cmd[3]) begin
         chk(16'(par[7] ? stby_cnt <= conv_cnt + 8 : stby_cnt >= FRM), 16'h1);
         rd(LPS_REG_ALS_HI, 1'b0, 2);
         chk({rb[0], rb[1]}, als_smp);
      end
   endtask
   initial begin
      srst = 1'b1;
      als_smp = 16'hc35a;
      error_cnt = 0;
      samples_checked = 0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(16'({stby, sink, dly, dead, cur, frq}), 16'h800a);
      rd(LPS_REG_ALS_PAR, 1'b1, 1);
      chk(16'(rb[0]), 16'h5);
      wr(LPS_REG_MOD_TIM, 8'he2);
      @(negedge clk);
      chk(16'({dly, dead}), 16'h3a);
      wr(LPS_REG_MOD_TIM, 8'h81);
      @(negedge clk);
      chk(16'({dly, dead}), 16'h21);
      rd(LPS_REG_PRX_FRQ, 1'b1, 2);
      chk(16'({rb[0], rb[1]}), 16'h0281);
      rd(LPS_REG_MOD_TIM, 1'b0, 2);
      chk(16'({rb[0], rb[1]}), 16'h8100);
      u_host.bitx(1'b1, 1'b0, 1'b1, r);
      u_host.wbyte(8'h28, ack);
      chk(16'(ack), 16'h0);
      u_host.bitx(1'b0, 1'b1, 1'b0, r);
      meas(8'h80, 8'h10);
      als_smp <= 16'h1ee7;
      meas(8'h83, 8'h10);
      meas(8'h87, 8'h10);
      meas(8'h02, 8'h10);
      meas(8'h02, 8'h08);
      tally_and_finish();
   end
   // Cuts a hang short well past the expected run length.
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end
endmodule
